// ### inc/lwc_pkg.sv
`default_nettype none
package lwc_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] LWC_OP_PIO = 8'h3F;
	localparam logic [7:0] LWC_OP_DMA = 8'h57;

	// ****************************************
	// Sector geometry
	// ****************************************
	localparam int         LWC_SECTOR_BYTES = 512;
	localparam int         LWC_WORD_BYTES   = 2;
	localparam int         LWC_SECTOR_WORDS = LWC_SECTOR_BYTES / LWC_WORD_BYTES;
	localparam logic [7:0] LWC_LAST_WORD    = 8'(LWC_SECTOR_WORDS - 1);

	// ****************************************
	// Error and status bytes
	// ****************************************
	localparam int         LWC_ERR_ABT_BIT  = 2;
	localparam int         LWC_ST_ERR_BIT   = 0;
	localparam int         LWC_ST_DSC_BIT   = 4;
	localparam int         LWC_ST_RDY_BIT   = 6;
	localparam logic [7:0] LWC_ERROR_NONE   = 8'h00;
	localparam logic [7:0] LWC_ERROR_ABORT  = 8'(1 << LWC_ERR_ABT_BIT);
	localparam logic [7:0] LWC_STATUS_OK    = 8'((1 << LWC_ST_RDY_BIT) | (1 << LWC_ST_DSC_BIT));
	localparam logic [7:0] LWC_STATUS_ABORT = 8'(LWC_STATUS_OK | (1 << LWC_ST_ERR_BIT));

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] countCur;
		logic [7:0] countPrev;
		logic [7:0] logAddr;
		logic [7:0] startCur;
		logic [7:0] startPrev;
	} lwc_cmd_t;

	typedef struct packed {
		logic        exists;
		logic        supported;
		logic        enabled;
		logic        readOnly;
		logic [15:0] size;
	} lwc_logattr_t;

	typedef struct packed {
		logic [7:0]  logAddr;
		logic [15:0] sector;
		logic [7:0]  word;
		logic [15:0] data;
	} lwc_logwr_t;

	typedef struct packed {
		logic       dma;
		logic [7:0] status;
		logic [7:0] error;
	} lwc_done_t;

	typedef struct packed {
		logic badFeature;
		logic readOnly;
		logic tooMany;
		logic badRange;
	} lwc_verdict_t;

	typedef enum logic [4:0] {
		LWC_IDLE   = 5'b0_0001,
		LWC_LOOKUP = 5'b0_0010,
		LWC_DECIDE = 5'b0_0100,
		LWC_XFER   = 5'b0_1000,
		LWC_FINISH = 5'b1_0000
	} lwc_state_t;

	typedef struct packed {
		lwc_state_t  state;
		logic        dma;
		logic        abort;
		logic [7:0]  logAddr;
		logic [15:0] count;
		logic [15:0] start;
		logic [15:0] sectorsDone;
		logic [7:0]  word;
		logic        wrValid;
		lwc_logwr_t  wr;
		logic        intrq;
		logic        doneValid;
		lwc_done_t   result;
	} lwc_main_t;

	function automatic logic lwc_is_log_write(input logic [7:0] op);
		return (op == LWC_OP_PIO) || (op == LWC_OP_DMA);
	endfunction

endpackage
`default_nettype wire

// ### rtl/lwc_param_check.sv
`default_nettype none
module lwc_param_check (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Parameters under test
	input  wire logic [15:0]           count,
	input  wire logic [15:0]           start,
	input  wire lwc_pkg::lwc_logattr_t attr,
	// Verdict, valid one edge after the inputs
	output var  lwc_pkg::lwc_verdict_t verdict,
	output var  logic                  abortCmd
);
	import lwc_pkg::*;

	lwc_verdict_t v_q;
	lwc_verdict_t v_d;
	logic [16:0]  endSector;

	// ****************************************
	// Checks
	// ****************************************
	always_comb begin
		endSector    = {1'b0, start} + {1'b0, count};
		v_d.badFeature = !attr.exists || !attr.supported || !attr.enabled;
		v_d.readOnly   = attr.readOnly;
		v_d.tooMany    = count > attr.size;
		// Zero count or a run past the end of the log is invalid
		v_d.badRange   = (count == 16'h0000) || (endSector > {1'b0, attr.size});
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			v_q <= '0;
		end else begin
			v_q <= v_d;
		end
	end

	assign verdict  = v_q;
	assign abortCmd = |v_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	count_over_size_a: assert property (
		(count > attr.size) |=> abortCmd && verdict.tooMany)
		else $error("count above log size not aborted");

	read_only_log_a: assert property (
		attr.readOnly |=> abortCmd)
		else $error("read-only log not aborted");

	feature_off_a: assert property (
		(!attr.supported || !attr.enabled) |=> abortCmd)
		else $error("unsupported log not aborted");

	bad_range_a: assert property (
		(count == 16'h0000) |=> verdict.badRange)
		else $error("zero count not flagged invalid");

endmodule
`default_nettype wire

// ### rtl/lwc_log_write.sv
`default_nettype none
module lwc_log_write (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Command block
	input  wire lwc_pkg::lwc_cmd_t     cmd,
	input  wire logic                  cmdValid,
	output logic                       cmdReady,
	// Log directory lookup
	output logic [7:0]                 dirAddr,
	input  wire lwc_pkg::lwc_logattr_t dirAttr,
	// Host data words
	input  wire logic [15:0]           hostData,
	input  wire logic                  hostValid,
	output logic                       hostReady,
	// Log store
	output var  lwc_pkg::lwc_logwr_t   logWr,
	output logic                       logWrValid,
	// Host signalling
	output logic                       busy,
	output logic                       drq,
	output logic                       dmaReq,
	output logic                       intrq,
	// Completion
	output logic                       doneValid,
	output var  lwc_pkg::lwc_done_t    doneResult
);
	import lwc_pkg::*;

	lwc_main_t    r_q;
	lwc_main_t    r_d;
	lwc_verdict_t verdict;
	logic         abortCmd;
	logic         accept;
	logic         wordLast;
	logic         sectorLast;
	logic         take;

	// ****************************************
	// Parameter check
	// ****************************************
	lwc_param_check u_check (
		.core_clk (core_clk),
		.rst      (rst),
		.count    (r_q.count),
		.start    (r_q.start),
		.attr     (dirAttr),
		.verdict  (verdict),
		.abortCmd (abortCmd)
	);

	// ****************************************
	// Handshakes
	// ****************************************
	assign cmdReady   = (r_q.state == LWC_IDLE);
	assign take       = cmdValid && cmdReady && lwc_is_log_write(cmd.opcode);
	assign hostReady  = (r_q.state == LWC_XFER);
	assign accept     = hostValid && hostReady;
	assign wordLast   = (r_q.word == LWC_LAST_WORD);
	assign sectorLast = (r_q.sectorsDone == 16'(r_q.count - 16'h0001));
	assign dirAddr    = r_q.logAddr;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_d           = r_q;
		r_d.wrValid   = 1'b0;
		r_d.intrq     = 1'b0;
		r_d.doneValid = 1'b0;
		unique case (r_q.state)
			LWC_IDLE: begin
				if (take) begin
					r_d.dma         = (cmd.opcode == LWC_OP_DMA);
					r_d.logAddr     = cmd.logAddr;
					r_d.count       = {cmd.countPrev, cmd.countCur};
					r_d.start       = {cmd.startPrev, cmd.startCur};
					r_d.sectorsDone = 16'h0000;
					r_d.word        = 8'h00;
					r_d.abort       = 1'b0;
					r_d.state       = LWC_LOOKUP;
				end
			end
			LWC_LOOKUP: begin
				// Checker samples the directory here, one edge of latency
				r_d.state = LWC_DECIDE;
			end
			LWC_DECIDE: begin
				// Same verdict path for both opcodes
				if (abortCmd) begin
					r_d.abort = 1'b1;
					r_d.state = LWC_FINISH;
				end else begin
					r_d.state = LWC_XFER;
				end
			end
			LWC_XFER: begin
				if (accept) begin
					r_d.wrValid    = 1'b1;
					r_d.wr.logAddr = r_q.logAddr;
					r_d.wr.sector  = 16'(r_q.start + r_q.sectorsDone);
					r_d.wr.word    = r_q.word;
					r_d.wr.data    = hostData;
					r_d.word       = 8'(r_q.word + 8'h01);
					if (wordLast) begin
						r_d.word        = 8'h00;
						r_d.sectorsDone = 16'(r_q.sectorsDone + 16'h0001);
						r_d.intrq       = !r_q.dma;
						if (sectorLast) begin
							r_d.state = LWC_FINISH;
						end
					end
				end
			end
			LWC_FINISH: begin
				r_d.doneValid     = 1'b1;
				r_d.result.dma    = r_q.dma;
				r_d.result.status = r_q.abort ? LWC_STATUS_ABORT : LWC_STATUS_OK;
				r_d.result.error  = r_q.abort ? LWC_ERROR_ABORT : LWC_ERROR_NONE;
				// PIO success already interrupted on its last sector
				r_d.intrq         = r_q.dma || r_q.abort;
				r_d.state         = LWC_IDLE;
			end
			default: begin
				r_d.state = LWC_IDLE;
			end
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r_q       <= '0;
			r_q.state <= LWC_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign logWr      = r_q.wr;
	assign logWrValid = r_q.wrValid;
	assign busy       = (r_q.state != LWC_IDLE);
	assign drq        = (r_q.state == LWC_XFER) && !r_q.dma;
	assign dmaReq     = (r_q.state == LWC_XFER) && r_q.dma;
	assign intrq      = r_q.intrq;
	assign doneValid  = r_q.doneValid;
	assign doneResult = r_q.result;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	pio_opcode_a: assert property (
		(cmdValid && cmdReady && cmd.opcode == LWC_OP_PIO)
		|=> r_q.state == LWC_LOOKUP && !r_q.dma ##2 (drq || r_q.state == LWC_FINISH))
		else $error("PIO opcode not started as PIO");

	dma_opcode_a: assert property (
		(cmdValid && cmdReady && cmd.opcode == LWC_OP_DMA)
		|=> r_q.dma ##2 (dmaReq || r_q.state == LWC_FINISH))
		else $error("DMA opcode not started as DMA");

	other_opcode_a: assert property (
		(cmdValid && cmdReady && !lwc_is_log_write(cmd.opcode)) |=> !busy)
		else $error("foreign opcode accepted");

	same_abort_a: assert property (
		(r_q.state == LWC_DECIDE && abortCmd)
		|-> ##2 doneValid && doneResult.error == LWC_ERROR_ABORT
		&& doneResult.status == LWC_STATUS_ABORT)
		else $error("abort not reported alike for both opcodes");

	sector_words_a: assert property (
		(accept && wordLast) |=> r_q.word == 8'h00
		&& r_q.sectorsDone == 16'($past(r_q.sectorsDone) + 16'h0001))
		else $error("sector not closed after 256 words");

	pio_block_irq_a: assert property (
		(accept && wordLast && !r_q.dma) |=> intrq)
		else $error("no interrupt after PIO block");

	count_pair_a: assert property (
		take |=> r_q.count == $past({cmd.countPrev, cmd.countCur})
		&& r_q.start == $past({cmd.startPrev, cmd.startCur}))
		else $error("count or start assembled wrongly");

	first_sector_a: assert property (
		(accept && r_q.sectorsDone == 16'h0000 && r_q.word == 8'h00)
		|=> logWrValid && logWr.sector == r_q.start && logWr.logAddr == r_q.logAddr)
		else $error("first word not at start sector");

	abort_no_data_a: assert property (
		(r_q.state == LWC_DECIDE && abortCmd) |=> !logWrValid [*2])
		else $error("data written on abort");

	// ****************************************
	// Transfer and completion checks
	// ****************************************
	xfer_both_a: assert property (
		(r_q.state == LWC_DECIDE && !abortCmd)
		|=> hostReady && (drq || dmaReq))
		else $error("clean command did not reach transfer");

	abort_finish_a: assert property (
		(r_q.state == LWC_DECIDE && abortCmd)
		|=> r_q.state == LWC_FINISH && !hostReady)
		else $error("abort did not skip the transfer");

	word_capture_a: assert property (
		accept
		|=> logWrValid && logWr.word == $past(r_q.word) && logWr.data == $past(hostData))
		else $error("accepted word not forwarded to the log");

	word_count_a: assert property (
		(accept && !wordLast)
		|=> r_q.word == 8'($past(r_q.word) + 8'h01))
		else $error("word index did not advance");

	sector_hold_a: assert property (
		(accept && r_q.word != 8'h00)
		|=> logWr.sector == $past(logWr.sector))
		else $error("sector changed inside a block");

	sector_step_a: assert property (
		(accept && r_q.word == 8'h00 && r_q.sectorsDone != 16'h0000)
		|=> logWr.sector == 16'($past(logWr.sector) + 16'h0001))
		else $error("next block not in the following sector");

	param_hold_a: assert property (
		busy
		|=> r_q.start == $past(r_q.start) && r_q.count == $past(r_q.count))
		else $error("command parameters changed while busy");

	log_target_a: assert property (
		accept |=> logWr.logAddr == $past(dirAddr))
		else $error("word written to another log");

	no_stray_write_a: assert property (
		!accept |=> !logWrValid)
		else $error("log written without an accepted word");

	last_sector_a: assert property (
		(accept && wordLast && sectorLast)
		|=> r_q.state == LWC_FINISH && r_q.sectorsDone == r_q.count)
		else $error("transfer length differs from count");

	done_code_a: assert property (
		doneValid
		|-> (doneResult.status == LWC_STATUS_OK && doneResult.error == LWC_ERROR_NONE)
		|| (doneResult.status == LWC_STATUS_ABORT && doneResult.error == LWC_ERROR_ABORT))
		else $error("completion code not recognised");

	dma_block_quiet_a: assert property (
		(accept && wordLast && r_q.dma) |=> !intrq)
		else $error("DMA raised a per-block interrupt");

	dma_done_irq_a: assert property (
		(doneValid && doneResult.dma) |-> intrq)
		else $error("DMA completion without interrupt");

	pio_single_irq_a: assert property (
		(doneValid && !doneResult.dma && doneResult.error == LWC_ERROR_NONE) |-> !intrq)
		else $error("PIO success interrupted twice");

	done_pulse_a: assert property (
		doneValid |=> !doneValid && !intrq)
		else $error("completion longer than one cycle");

	abort_quiet_a: assert property (
		r_q.abort |-> !hostReady)
		else $error("aborted command offered data space");

	dma_mode_a: assert property (
		(r_q.state == LWC_XFER && r_q.dma) |-> dmaReq && !drq)
		else $error("DMA transfer signalled as PIO");

	cover_pio_ok: cover property (doneValid && !doneResult.dma
		&& doneResult.error == LWC_ERROR_NONE);
	cover_dma_ok: cover property (doneValid && doneResult.dma
		&& doneResult.error == LWC_ERROR_NONE);
	cover_abort: cover property (doneValid && doneResult.error == LWC_ERROR_ABORT);
	cover_ro_abort: cover property (r_q.state == LWC_DECIDE && verdict.readOnly);
	cover_pio_multi: cover property (accept && wordLast && sectorLast && !r_q.dma
		&& r_q.count > 16'h0001);

endmodule
`default_nettype wire

// ### sim/lwc_host_model.sv
`default_nettype none
module lwc_host_model (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Directory lookup
	input  wire logic [7:0]            dirAddr,
	output var  lwc_pkg::lwc_logattr_t dirAttr,
	// Data words
	input  wire logic                  slow,
	input  wire logic                  hostReady,
	output var  logic [15:0]           hostData,
	output var  logic                  hostValid
);
	import lwc_pkg::*;

	logic [15:0] sent_q;
	logic        phase_q;

	// ****************************************
	// Directory: 80h is the only writable log
	// ****************************************
	always_comb begin
		case (dirAddr)
			8'h80: dirAttr = '{1'b1, 1'b1, 1'b1, 1'b0, 16'h0010};
			8'h81: dirAttr = '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0010};
			8'h82: dirAttr = '{1'b1, 1'b0, 1'b1, 1'b0, 16'h0010};
			8'h83: dirAttr = '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0010};
			default: dirAttr = '0;
		endcase
	end

	// Offer held until taken; slow mode drops valid on alternate cycles
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sent_q <= 16'h0000;
			phase_q <= 1'b0;
			hostValid <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
			if (hostValid && hostReady) begin
				sent_q <= sent_q + 16'h0001;
			end
			if (!(hostValid && !hostReady)) begin
				hostValid <= !(slow && phase_q);
			end
		end
	end

	// Idle bus shows the inverse so a stale word never matches
	assign hostData = hostValid ? (sent_q ^ 16'h5A5A) : ~(sent_q ^ 16'h5A5A);
endmodule
`default_nettype wire

// ### sim/lwc_log_write_tb.sv
`default_nettype none
module lwc_log_write_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lwc_pkg::*;

	logic         core_clk = 1'b0;
	logic         rst      = 1'b1;
	lwc_cmd_t     cmd      = '0;
	logic         cmdValid = 1'b0;
	logic         slow     = 1'b0;
	logic         cmdReady, hostReady, hostValid, logWrValid;
	logic         busy, drq, dmaReq, intrq, doneValid;
	logic [7:0]   dirAddr;
	logic [15:0]  hostData;
	lwc_logattr_t dirAttr;
	lwc_logwr_t   logWr;
	lwc_done_t    doneResult;
	logic [48:0]  expQ[$];
	logic [31:0]  rng      = 32'h0001_28C0;
	int           failures = 0;
	int           checks   = 0;
	int           irqs, dones, words;
	logic         sawDrq, sawDma;

	always #5 core_clk = ~core_clk;

	lwc_log_write dut (.core_clk(core_clk), .rst(rst), .cmd(cmd), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .dirAddr(dirAddr), .dirAttr(dirAttr), .hostData(hostData),
		.hostValid(hostValid), .hostReady(hostReady), .logWr(logWr), .logWrValid(logWrValid),
		.busy(busy), .drq(drq), .dmaReq(dmaReq), .intrq(intrq), .doneValid(doneValid),
		.doneResult(doneResult));

	lwc_host_model host (.core_clk(core_clk), .rst(rst), .dirAddr(dirAddr), .dirAttr(dirAttr),
		.slow(slow), .hostReady(hostReady), .hostData(hostData), .hostValid(hostValid));

	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic compare(input logic [48:0] got, input logic [48:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("counts: checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************************************
	// Result watcher, sampled mid-cycle
	// ****************************************
	always @(negedge core_clk) begin
		if (logWrValid === 1'b1) begin
			compare({1'b0, logWr}, expQ.size() ? expQ.pop_front() : ~{1'b0, logWr});
		end
		if (doneValid === 1'b1) begin
			compare({1'b1, 31'h0, doneResult}, expQ.size() ? expQ.pop_front() : 49'h0);
			dones++;
		end
		if (intrq === 1'b1) irqs++;
		if (drq === 1'b1) sawDrq = 1'b1;
		if (dmaReq === 1'b1) sawDma = 1'b1;
	end

	task automatic run_cmd(input logic [7:0] op, input logic [7:0] log, input logic [15:0] cnt,
			input logic [15:0] st, input logic slw, input logic ok);
		int   n;
		logic isDma;
		isDma = (op == LWC_OP_DMA);
		if (ok) begin
			for (int s = 0; s < cnt; s++) for (int w = 0; w < 256; w++) begin
				expQ.push_back({1'b0, log, st + 16'(s), 8'(w), 16'(words) ^ 16'h5A5A});
				words++;
			end
		end
		expQ.push_back({1'b1, 31'h0, isDma, ok ? LWC_STATUS_OK : LWC_STATUS_ABORT,
			ok ? LWC_ERROR_NONE : LWC_ERROR_ABORT});
		irqs = 0;
		dones = 0;
		sawDrq = 1'b0;
		sawDma = 1'b0;
		@(posedge core_clk);
		#1;
		slow = slw;
		cmd = '{op, cnt[7:0], cnt[15:8], log, st[7:0], st[15:8]};
		cmdValid = 1'b1;
		do @(posedge core_clk); while (cmdReady !== 1'b1);
		#1 cmdValid = 1'b0;
		n = 0;
		while (dones == 0 && n < 20000) begin
			@(posedge core_clk);
			n++;
		end
		compare(49'(dones), 49'h1);
		compare(49'({sawDrq, sawDma, 16'(irqs)}),
			49'({ok && !isDma, ok && isDma, (ok && !isDma) ? cnt : 16'h0001}));
		compare(49'(expQ.size()), 49'h0);
		$display("test op=%h log=%h cnt=%h start=%h ended", op, log, cnt, st);
	endtask

	initial begin
		#400_000;
		failures++;
		give_verdict();
	end

	initial begin
		int c;
		int s;
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rng = xorshift(rng);
			c = 1 + rng[1:0];
			s = rng[15:4] % (17 - c);
			run_cmd(i[0] ? 8'h57 : 8'h3F, 8'h80, 16'(c), 16'(s), rng[20], 1'b1);
		end
		run_cmd(8'h3F, 8'h80, 16'h0010, 16'h0000, 1'b1, 1'b1);
		run_cmd(8'h57, 8'h80, 16'h0011, 16'h0000, 1'b0, 1'b0);
		run_cmd(8'h3F, 8'h80, 16'h0101, 16'h0000, 1'b0, 1'b0);
		run_cmd(8'h3F, 8'h80, 16'h0001, 16'h0100, 1'b0, 1'b0);
		run_cmd(8'h3F, 8'h80, 16'h0001, 16'h000F, 1'b0, 1'b1);
		run_cmd(8'h3F, 8'h80, 16'h0002, 16'h000F, 1'b0, 1'b0);
		run_cmd(8'h57, 8'h80, 16'h0000, 16'h0000, 1'b0, 1'b0);
		run_cmd(8'h3F, 8'h90, 16'h0001, 16'h0000, 1'b0, 1'b0);
		run_cmd(8'h3F, 8'h81, 16'h0001, 16'h0000, 1'b0, 1'b0);
		run_cmd(8'h57, 8'h81, 16'h0001, 16'h0000, 1'b0, 1'b0);
		run_cmd(8'h3F, 8'h82, 16'h0001, 16'h0000, 1'b0, 1'b0);
		run_cmd(8'h57, 8'h83, 16'h0001, 16'h0000, 1'b0, 1'b0);
		// Reset in flight drops the command without a completion
		dones = 0;
		#1 cmd = '{LWC_OP_DMA, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00};
		cmdValid = 1'b1;
		@(posedge core_clk);
		#1 cmdValid = 1'b0;
		compare(49'(busy), 49'h1);
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		words = 0;
		repeat (8) @(posedge core_clk);
		compare(49'({busy, cmdReady, drq, dmaReq, 16'(dones)}), 49'({4'h4, 16'h0000}));
		$display("test reset in flight ended");
		// Foreign opcode must leave the block idle
		dones = 0;
		#1 cmd.opcode = 8'hEC;
		cmdValid = 1'b1;
		@(posedge core_clk);
		#1 cmdValid = 1'b0;
		repeat (8) @(posedge core_clk);
		compare(49'({busy, 16'(dones)}), 49'h0);
		$display("test foreign opcode ended");
		give_verdict();
	end
endmodule
`default_nettype wire
